// File: bench/cpu_bus_model.sv
// processor-side model reaching the timer registers over axi4-lite
`timescale 1ns/1ps
module cpu_bus_model
	import paired_timer_pkg::*;
(
	input  wire logic         i_clk,             // system clock
	output logic [ADDR_W-1:0] o_awaddr = '0,     // aw addr
	output logic              o_awvalid = 1'b0,  // aw valid
	input  wire logic         i_awready,         // aw ready
	output logic [31:0]       o_wdata = '0,      // w data
	output logic [3:0]        o_wstrb = '0,      // w strobes
	output logic              o_wvalid = 1'b0,   // w valid
	input  wire logic         i_wready,          // w ready
	input  wire logic [1:0]   i_bresp,           // b resp
	input  wire logic         i_bvalid,          // b valid
	output logic              o_bready = 1'b0,   // b ready
	output logic [ADDR_W-1:0] o_araddr = '0,     // ar addr
	output logic              o_arvalid = 1'b0,  // ar valid
	input  wire logic         i_arready,         // ar ready
	input  wire logic [31:0]  i_rdata,           // r data
	input  wire logic [1:0]   i_rresp,           // r resp
	input  wire logic         i_rvalid,          // r valid
	output logic              o_rready = 1'b0    // r ready
);
	// no latency assumed; the bound only cuts a hung slave short
	task automatic xfer(input bit we, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic [1:0] r, output bit hung);
		int n;
		n = 0;
		@(posedge i_clk);
		o_awaddr <= a;
		o_araddr <= a;
		o_wdata <= wd;
		o_wstrb <= 4'hf;
		o_awvalid <= we;
		o_wvalid <= we;
		o_bready <= we;
		o_arvalid <= !we;
		o_rready <= !we;
		do begin
			@(posedge i_clk);
			n++;
			if (i_awready)
				o_awvalid <= 1'b0;
			if (i_wready)
				o_wvalid <= 1'b0;
			if (i_arready)
				o_arvalid <= 1'b0;
		end while (!(we ? i_bvalid : i_rvalid) && n < 200);
		o_bready <= 1'b0;
		o_rready <= 1'b0;
		r = we ? i_bresp : i_rresp;
		rd = i_rdata;
		hung = n >= 200;
	endtask : xfer
endmodule : cpu_bus_model

// File: bench/tb.sv
// self-checking bench for the paired 16/32-bit timer
`timescale 1ns/1ps
module tb
	import paired_timer_pkg::*;
;
	localparam logic [15:0] RUN32 = 16'((1 << TIMER_ON_BIT) | (1 << CHAIN_BIT));
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              cpu_idle = 1'b0;
	logic              cpu_sleep = 1'b0;
	logic              low_pin = 1'b0;
	logic              high_pin = 1'b0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, d;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, r;
	logic              awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic              low_irq, high_irq, adc_trig;
	bit                h;
	int                miscompares = 0;
	int                tests_run = 0;
	int                seed = 32'h8f71a296;
	int                n, p, g;
	logic [ADDR_W-1:0] regs[6] = '{LOW_COUNT_ADDR, HIGH_COUNT_ADDR, LOW_PER_ADDR, HIGH_PER_ADDR, LOW_CTL_ADDR, HIGH_CTL_ADDR};
	logic [31:0]       resets[6] = '{32'h0, 32'h0, 32'hffff, 32'hffff, 32'h0, 32'h0};

	paired_timer_16_32 i_dut (
		.i_clk(clk), .i_sys_rst(sys_rst), .i_cpu_idle(cpu_idle), .i_cpu_sleep(cpu_sleep),
		.i_low_clk_gate(low_pin), .i_high_clk(high_pin),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
		.o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
		.o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
		.o_low_irq(low_irq), .o_high_irq(high_irq), .o_adc_trigger(adc_trig)
	);
	cpu_bus_model i_cpu (
		.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
		.o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid),
		.o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
		.i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready)
	);

	initial begin
		forever #12.5 clk = ~clk;
	end

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : check
	task automatic hang(input bit stuck);
		if (stuck) begin
			miscompares++;
			$display("unexpected at %0t: wait ran out", $time);
			summarize();
		end
	endtask : hang
	task automatic acc(input bit we, input logic [ADDR_W-1:0] a, input logic [31:0] v, input logic [1:0] er);
		i_cpu.xfer(we, a, v, d, r, h);
		hang(h);
		check({30'h0, r}, {30'h0, er});
	endtask : acc
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		acc(1'b1, a, v, RESP_OKAY);
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a);
		acc(1'b0, a, 32'h0, RESP_OKAY);
	endtask : rd
	// stop, zero counts, set period, start
	task automatic arm(input logic [15:0] ctl, input logic [15:0] per);
		wr(LOW_CTL_ADDR, 32'h0);
		wr(LOW_COUNT_ADDR, 32'h0);
		wr(HIGH_COUNT_ADDR, 32'h0);
		wr(LOW_PER_ADDR, {16'h0, per});
		wr(HIGH_PER_ADDR, 32'h0);
		wr(LOW_CTL_ADDR, {16'h0, ctl});
	endtask : arm
	task automatic wait_trig(output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (adc_trig !== 1'b1 && cnt < 20000);
		hang(cnt >= 20000);
	endtask : wait_trig
	task automatic count_trig(output int cnt);
		cnt = 0;
		repeat (80) begin
			@(posedge clk);
			cnt += (adc_trig === 1'b1);
		end
	endtask : count_trig
	function automatic int div_of(input int s);
		return (s == 3) ? 256 : (1 << (3 * s));
	endfunction : div_of

	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (regs[i]) begin
			rd(regs[i]);
			check(d, resets[i]);
		end
		acc(1'b1, 12'h004, 32'h5a5a, RESP_SLVERR);
		acc(1'b0, 12'h004, 32'h0, RESP_SLVERR);
		$display("reset done");
		g = {$random(seed)} % 65536;
		wr(LOW_CTL_ADDR, 32'h1 << CHAIN_BIT);
		wr(HOLD_ADDR, 32'(g));
		wr(LOW_COUNT_ADDR, 32'h5);
		rd(HIGH_COUNT_ADDR);
		check(d, 32'(g));
		wr(LOW_CTL_ADDR, {16'h0, 16'($random(seed)) & LOW_CTL_MASK & 16'h7fff});
		wr(HOLD_ADDR, 32'h0);
		rd(LOW_COUNT_ADDR);
		check(d, 32'h5);
		rd(HOLD_ADDR);
		check(d, 32'(g));
		$display("coherent done");
		for (int s = 0; s < 4; s++) begin
			p = 3 + {$random(seed)} % 17;
			arm(RUN32 | 16'(s << PS_LSB), 16'(p));
			wr(HIGH_CTL_ADDR, {16'h0, 16'($random(seed)) & HIGH_CTL_MASK});
			wait_trig(n);
			wait_trig(n);
			check(32'(n), 32'((p + 1) * div_of(s)));
		end
		wr(LOW_CTL_ADDR, 32'h0);
		wr(HIGH_COUNT_ADDR, 32'h0);
		wr(HIGH_PER_ADDR, 32'(p));
		wr(HIGH_CTL_ADDR, 32'h1 << TIMER_ON_BIT);
		wait_trig(n);
		wait_trig(n);
		check(32'(n), 32'(p + 1));
		wr(HIGH_CTL_ADDR, 32'h0);
		$display("period done");
		arm(RUN32 | 16'(1 << IDLE_STOP_BIT), 16'h7);
		cpu_idle <= 1'b1;
		repeat (4) @(posedge clk);
		count_trig(n);
		check(32'(n), 32'h0);
		wr(LOW_CTL_ADDR, {16'h0, RUN32});
		count_trig(n);
		check(32'(n > 0), 32'h1);
		cpu_sleep <= 1'b1;
		repeat (4) @(posedge clk);
		count_trig(n);
		check(32'(n), 32'h0);
		cpu_idle <= 1'b0;
		cpu_sleep <= 1'b0;
		$display("idle done");
		arm(RUN32 | 16'(1 << GATE_BIT), 16'hffff);
		wr(HIGH_CTL_ADDR, 32'h1 << GATE_BIT);
		wr(IRQ_EN_ADDR, 32'h3);
		wr(IRQ_FLAG_ADDR, 32'h0);
		rd(LOW_COUNT_ADDR);
		check(d, 32'h0);
		g = 10 + {$random(seed)} % 30;
		low_pin <= 1'b1;
		repeat (g) @(posedge clk);
		low_pin <= 1'b0;
		repeat (10) @(posedge clk);
		rd(LOW_COUNT_ADDR);
		check(d, 32'(g));
		check({31'h0, high_irq}, 32'h1);
		check({31'h0, low_irq}, 32'h0);
		wr(IRQ_FLAG_ADDR, 32'h0);
		repeat (2) @(posedge clk);
		check({31'h0, high_irq}, 32'h0);
		$display("gate done");
		arm(RUN32 | 16'(1 << CLK_SRC_BIT), 16'hffff);
		g = 5 + {$random(seed)} % 16;
		repeat (g) begin
			low_pin <= 1'b1;
			high_pin <= 1'($random(seed));
			repeat (3) @(posedge clk);
			low_pin <= 1'b0;
			repeat (3) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		rd(LOW_COUNT_ADDR);
		check(d, 32'(g));
		$display("count done");
		summarize();
	end
endmodule : tb

// File: bench/timer_monitor.sv
// assertion checker for the paired timer register port and event outputs
`timescale 1ns/1ps
module timer_monitor (
	input wire logic        i_clk,           // system clock
	input wire logic        i_sys_rst,       // synchronous reset
	input wire logic        i_cpu_sleep,     // cpu sleep level
	input wire logic        i_s_axi_awvalid, // aw valid
	input wire logic        i_s_axi_wvalid,  // w valid
	input wire logic        o_s_axi_awready, // aw ready
	input wire logic        o_s_axi_wready,  // w ready
	input wire logic [1:0]  o_s_axi_bresp,   // b resp
	input wire logic        o_s_axi_bvalid,  // b valid
	input wire logic        i_s_axi_bready,  // b ready
	input wire logic        o_s_axi_arready, // ar ready
	input wire logic [31:0] o_s_axi_rdata,   // r data
	input wire logic        o_s_axi_rvalid,  // r valid
	input wire logic        i_s_axi_rready,  // r ready
	input wire logic        o_high_irq,      // high-word interrupt
	input wire logic        o_adc_trigger    // converter trigger
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_wr_taken;
		o_s_axi_awready && i_s_axi_awvalid && i_s_axi_wvalid;
	endsequence
	// four cycles lets a trigger already in flight drain
	sequence s_asleep;
		i_cpu_sleep [*4];
	endsequence
	a_wr_answer: assert property (s_wr_taken |=> o_s_axi_bvalid)
		else $error("write response missing");
	a_ready_pair: assert property (o_s_axi_awready == o_s_axi_wready)
		else $error("address and data ready differ");
	a_bresp_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped");
	a_rd_answer: assert property (o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read data missing");
	a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data dropped");
	a_trig_pulse: assert property (o_adc_trigger |=> !o_adc_trigger)
		else $error("trigger longer than one cycle");
	a_sleep_quiet: assert property (s_asleep |-> !o_adc_trigger)
		else $error("trigger during sleep");
	a_irq_sticky: assert property (o_high_irq && !o_s_axi_awready |=> o_high_irq)
		else $error("interrupt cleared without a write");
endmodule : timer_monitor

bind paired_timer_16_32 timer_monitor i_mon (
	.i_clk, .i_sys_rst, .i_cpu_sleep, .i_s_axi_awvalid, .i_s_axi_wvalid, .o_s_axi_awready,
	.o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .o_s_axi_arready,
	.o_s_axi_rdata, .o_s_axi_rvalid, .i_s_axi_rready, .o_high_irq, .o_adc_trigger
);

// File: hdl/paired_timer_16_32.sv
// paired 16-bit timers, chainable to 32 bits, with axi4-lite registers
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module paired_timer_16_32
	import paired_timer_pkg::*;
(
	input  wire logic              i_clk,            // 40 MHz instruction clock
	input  wire logic              i_sys_rst,        // synchronous reset, high
	input  wire logic              i_cpu_idle,       // cpu idle level
	input  wire logic              i_cpu_sleep,      // cpu sleep level
	input  wire logic              i_low_clk_gate,   // low-word external clock / gate pin
	input  wire logic              i_high_clk,       // high-word external clock pin
	input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,   // aw addr
	input  wire logic              i_s_axi_awvalid,  // aw valid
	output logic                   o_s_axi_awready,  // aw ready
	input  wire logic [31:0]       i_s_axi_wdata,    // w data
	input  wire logic [3:0]        i_s_axi_wstrb,    // w strobes
	input  wire logic              i_s_axi_wvalid,   // w valid
	output logic                   o_s_axi_wready,   // w ready
	output logic [1:0]             o_s_axi_bresp,    // b resp
	output logic                   o_s_axi_bvalid,   // b valid
	input  wire logic              i_s_axi_bready,   // b ready
	input  wire logic [ADDR_W-1:0] i_s_axi_araddr,   // ar addr
	input  wire logic              i_s_axi_arvalid,  // ar valid
	output logic                   o_s_axi_arready,  // ar ready
	output logic [31:0]            o_s_axi_rdata,    // r data
	output logic [1:0]             o_s_axi_rresp,    // r resp
	output logic                   o_s_axi_rvalid,   // r valid
	input  wire logic              i_s_axi_rready,   // r ready
	output logic                   o_low_irq,        // low-word interrupt request
	output logic                   o_high_irq,       // high-word interrupt request
	output logic                   o_adc_trigger     // converter trigger pulse
);
	typedef struct packed {
		logic        wr_rdy;
		logic        b_valid;
		logic [1:0]  b_resp;
		logic        ar_rdy;
		logic        r_valid;
		logic [1:0]  r_resp;
		logic [31:0] r_data;
		logic [15:0] low_count_reg;
		logic [15:0] high_count_reg;
		logic [15:0] high_word_holding_reg;
		logic [15:0] low_period_reg;
		logic [15:0] high_period_reg;
		logic [15:0] low_timer_control;
		logic [15:0] high_timer_control;
		logic        low_flag;
		logic        high_timer_irq_flag;
		logic        low_ie;
		logic        high_timer_irq_enable;
		logic        low_irq;
		logic        high_irq;
		logic        adc_trig;
		logic        gate_prev;
		logic        high_ext_prev;
	} timer_s;

	timer_s      s;
	timer_s      next_s;
	logic        gate_lvl;
	logic        high_ext_lvl;
	logic        low_ps_tick;
	logic        high_ps_tick;
	logic        chain_32_select;
	logic        low_run;
	logic        high_run;
	logic        low_src;
	logic        high_src;
	logic        gate_fall;
	logic        wr_go;
	logic        rd_go;
	logic        ps_low_clear;
	logic        ps_high_clear;
	logic [15:0] wr_val;
	logic [15:0] rd_val;
	logic        rd_hit;
	logic        wr_hit;
	logic [31:0] count32;
	logic [31:0] period32;
	logic        low_match;
	logic        high_match;
	logic        low_ton_drop;
	logic        high_ton_drop;

	pin_sync u_gate_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_pin     (i_low_clk_gate),
		.o_level   (gate_lvl)
	);

	pin_sync u_high_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_pin     (i_high_clk),
		.o_level   (high_ext_lvl)
	);

	assign wr_go           = s.wr_rdy;
	assign rd_go           = s.ar_rdy & i_s_axi_arvalid;
	assign chain_32_select = s.low_timer_control[CHAIN_BIT];
	// byte lanes 0 and 1 carry the 16-bit register; upper lanes ignored
	function automatic logic [15:0] merge(input logic [15:0] old);
		merge = old;
		if (i_s_axi_wstrb[0])
			merge[7:0] = i_s_axi_wdata[7:0];
		if (i_s_axi_wstrb[1])
			merge[15:8] = i_s_axi_wdata[15:8];
	endfunction : merge

	// enable dropping through a control write clears the prescaler
	always_comb begin
		wr_val        = merge(s.low_timer_control);
		low_ton_drop  = wr_go && i_s_axi_awaddr == LOW_CTL_ADDR && s.low_timer_control[TIMER_ON_BIT]
		                && !wr_val[TIMER_ON_BIT];
		wr_val        = merge(s.high_timer_control);
		high_ton_drop = wr_go && i_s_axi_awaddr == HIGH_CTL_ADDR && s.high_timer_control[TIMER_ON_BIT]
		                && !wr_val[TIMER_ON_BIT];
		ps_low_clear  = (wr_go && (i_s_axi_awaddr == LOW_COUNT_ADDR || i_s_axi_awaddr == HIGH_COUNT_ADDR))
		                || low_ton_drop || high_ton_drop;
		ps_high_clear = ps_low_clear;
	end

	// run conditions: sleep stops everything, idle-stop halts in idle
	always_comb begin
		low_run  = s.low_timer_control[TIMER_ON_BIT] && !i_cpu_sleep
		           && !(i_cpu_idle && s.low_timer_control[IDLE_STOP_BIT]);
		high_run = !chain_32_select && s.high_timer_control[TIMER_ON_BIT] && !i_cpu_sleep
		           && !(i_cpu_idle && s.high_timer_control[IDLE_STOP_BIT]);
		// external source counts synchronised rising edges only
		if (s.low_timer_control[CLK_SRC_BIT]) begin
			low_src = gate_lvl && !s.gate_prev;
		end else if (s.low_timer_control[GATE_BIT]) begin
			low_src = gate_lvl;
		end else begin
			low_src = 1'b1;
		end
		if (s.high_timer_control[CLK_SRC_BIT]) begin
			high_src = high_ext_lvl && !s.high_ext_prev;
		end else if (s.high_timer_control[GATE_BIT]) begin
			high_src = high_ext_lvl;
		end else begin
			high_src = 1'b1;
		end
		gate_fall = !gate_lvl && s.gate_prev && s.low_timer_control[GATE_BIT]
		            && s.low_timer_control[TIMER_ON_BIT] && !s.low_timer_control[CLK_SRC_BIT];
	end

	timer_prescaler #(
		.SYNC_OUT (1'b1)
	) u_low_ps (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_enable  (s.low_timer_control[TIMER_ON_BIT]),
		.i_clear   (ps_low_clear),
		.i_tick    (low_run && low_src),
		.i_select  (s.low_timer_control[PS_LSB +: 2]),
		.o_tick    (low_ps_tick)
	);

	timer_prescaler #(
		.SYNC_OUT (1'b0)
	) u_high_ps (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_enable  (s.high_timer_control[TIMER_ON_BIT] && !chain_32_select),
		.i_clear   (ps_high_clear),
		.i_tick    (high_run && high_src),
		.i_select  (s.high_timer_control[PS_LSB +: 2]),
		.o_tick    (high_ps_tick)
	);

	assign count32    = {s.high_count_reg, s.low_count_reg};
	assign period32   = {s.high_period_reg, s.low_period_reg};
	assign low_match  = s.low_count_reg == s.low_period_reg;
	assign high_match = s.high_count_reg == s.high_period_reg;

	// register read decode
	always_comb begin
		rd_hit = 1'b1;
		case (i_s_axi_araddr)
			LOW_COUNT_ADDR:  rd_val = s.low_count_reg;
			HOLD_ADDR:       rd_val = s.high_word_holding_reg;
			HIGH_COUNT_ADDR: rd_val = s.high_count_reg;
			LOW_PER_ADDR:    rd_val = s.low_period_reg;
			HIGH_PER_ADDR:   rd_val = s.high_period_reg;
			LOW_CTL_ADDR:    rd_val = s.low_timer_control;
			HIGH_CTL_ADDR:   rd_val = s.high_timer_control;
			IRQ_FLAG_ADDR: begin
				rd_val               = '0;
				rd_val[LOW_IRQ_BIT]  = s.low_flag;
				rd_val[HIGH_IRQ_BIT] = s.high_timer_irq_flag;
			end
			IRQ_EN_ADDR: begin
				rd_val               = '0;
				rd_val[LOW_IRQ_BIT]  = s.low_ie;
				rd_val[HIGH_IRQ_BIT] = s.high_timer_irq_enable;
			end
			default: begin
				rd_val = '0;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		case (i_s_axi_awaddr)
			LOW_COUNT_ADDR, HOLD_ADDR, HIGH_COUNT_ADDR, LOW_PER_ADDR, HIGH_PER_ADDR,
			LOW_CTL_ADDR, HIGH_CTL_ADDR, IRQ_FLAG_ADDR, IRQ_EN_ADDR: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		next_s          = s;
		next_s.adc_trig = 1'b0;

		// bus handshakes: write ready is a one-cycle pulse once aw and w are both offered, read ready once ar is
		next_s.wr_rdy = i_s_axi_awvalid && i_s_axi_wvalid && !s.wr_rdy && !s.b_valid;
		if (wr_go) begin
			next_s.b_valid = 1'b1;
			next_s.b_resp  = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s.b_valid && i_s_axi_bready) begin
			next_s.b_valid = 1'b0;
		end
		next_s.ar_rdy = i_s_axi_arvalid && !s.ar_rdy && !s.r_valid;
		if (rd_go) begin
			next_s.r_valid = 1'b1;
			next_s.r_data  = {16'h0000, rd_val};
			next_s.r_resp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
			if (i_s_axi_araddr == LOW_COUNT_ADDR) begin
				next_s.high_word_holding_reg = s.high_count_reg;
			end
		end else if (s.r_valid && i_s_axi_rready) begin
			next_s.r_valid = 1'b0;
		end

		// counting
		if (chain_32_select) begin
			if (low_ps_tick && low_run) begin
				if (count32 == period32) begin
					next_s.low_count_reg  = '0;
					next_s.high_count_reg = '0;
					next_s.adc_trig       = 1'b1;
				end else begin
					{next_s.high_count_reg, next_s.low_count_reg} = count32 + 32'h0000_0001;
				end
			end
		end else begin
			if (low_ps_tick && low_run) begin
				next_s.low_count_reg = low_match ? '0 : s.low_count_reg + 16'h0001;
			end
			if (high_ps_tick && high_run) begin
				next_s.high_count_reg = high_match ? '0 : s.high_count_reg + 16'h0001;
				next_s.adc_trig       = high_match;
			end
		end

		// register writes; only count writes touch counts
		if (wr_go) begin
			case (i_s_axi_awaddr)
				LOW_COUNT_ADDR: begin
					next_s.low_count_reg = merge(s.low_count_reg);
					if (chain_32_select) begin
						next_s.high_count_reg = s.high_word_holding_reg;
					end
				end
				HOLD_ADDR:       next_s.high_word_holding_reg =
				                 merge(s.high_word_holding_reg);
				HIGH_COUNT_ADDR: next_s.high_count_reg = merge(s.high_count_reg);
				LOW_PER_ADDR:    next_s.low_period_reg = merge(s.low_period_reg);
				HIGH_PER_ADDR:   next_s.high_period_reg = merge(s.high_period_reg);
				LOW_CTL_ADDR:    next_s.low_timer_control = LOW_CTL_MASK &
				                 merge(s.low_timer_control);
				HIGH_CTL_ADDR:   next_s.high_timer_control = HIGH_CTL_MASK &
				                 merge(s.high_timer_control);
				IRQ_FLAG_ADDR: if (i_s_axi_wstrb[0]) begin
					next_s.low_flag            = i_s_axi_wdata[LOW_IRQ_BIT];
					next_s.high_timer_irq_flag = i_s_axi_wdata[HIGH_IRQ_BIT];
				end
				IRQ_EN_ADDR: if (i_s_axi_wstrb[0]) begin
					next_s.low_ie                = i_s_axi_wdata[LOW_IRQ_BIT];
					next_s.high_timer_irq_enable = i_s_axi_wdata[HIGH_IRQ_BIT];
				end
				default: begin
				end
			endcase
		end

		// flag sets come after software writes so an event is never lost
		if (chain_32_select) begin
			if ((low_ps_tick && low_run && count32 == period32) || gate_fall) begin
				next_s.high_timer_irq_flag = 1'b1;
			end
		end else begin
			if ((low_ps_tick && low_run && low_match) || gate_fall) begin
				next_s.low_flag = 1'b1;
			end
			if (high_ps_tick && high_run && high_match) begin
				next_s.high_timer_irq_flag = 1'b1;
			end
		end

		next_s.low_irq       = next_s.low_flag && next_s.low_ie;
		next_s.high_irq      = next_s.high_timer_irq_flag && next_s.high_timer_irq_enable;
		next_s.gate_prev     = gate_lvl;
		next_s.high_ext_prev = high_ext_lvl;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s                    <= '0;
			s.low_count_reg      <= COUNT_RESET;
			s.high_count_reg     <= COUNT_RESET;
			s.low_period_reg     <= PERIOD_RESET;
			s.high_period_reg    <= PERIOD_RESET;
			s.low_timer_control  <= CTL_RESET;
			s.high_timer_control <= CTL_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign o_s_axi_awready = s.wr_rdy;
	assign o_s_axi_wready  = s.wr_rdy;
	assign o_s_axi_bvalid  = s.b_valid;
	assign o_s_axi_bresp   = s.b_resp;
	assign o_s_axi_arready = s.ar_rdy;
	assign o_s_axi_rvalid  = s.r_valid;
	assign o_s_axi_rdata   = s.r_data;
	assign o_s_axi_rresp   = s.r_resp;
	assign o_low_irq       = s.low_irq;
	assign o_high_irq      = s.high_irq;
	assign o_adc_trigger   = s.adc_trig;
endmodule : paired_timer_16_32

// File: hdl/paired_timer_pkg.sv
// constants for the paired 16/32-bit timer block
// Operation
// - chained: low timer is bits 15:0, high timer bits 31:16.
// - chained: high control ignored, except that clearing its enable clears the low prescaler; low control, clock and gate rule.
// - chained: interrupt via high flag and high enable.
// - unchained: two independent timers or synchronous counters, no asynchronous mode; a count write or enable clear on either clears both prescalers.
// - low prescaler output resynchronised, high one not.
// - chained timer counts each cycle to 32-bit period, then zero.
// - low count read latches high count into holding register.
// - chained: write holding, then low count; that write loads high count.
// - chained counter counts synchronised external rising edges to period.
// - counter stops in idle when idle-stop set, else runs.
// - gate mode counts cycles while gate pin high, internal clock.
// - chained gate uses low gate; high gate enable no effect.
// - falling gate edge ends accumulation, count kept; software clears it.
// - 32-bit period match sends converter trigger.
// - prescaler divides by 1, 8, 64 or 256, select at bits 5:4.
// - chained: only low prescaler acts.
// - prescaler cleared by count writes, enable clears, device reset.
// - disabled timer halts prescaler; no clearing then.
// - control writes leave counts unchanged.
// - nothing counts during cpu sleep.
// - chained: 32-bit match or falling gate sets high flag; software clears.
package paired_timer_pkg;
	localparam int          ADDR_W         = 12;
	// register indices; byte address is four times the index
	localparam logic [11:0] LOW_COUNT_IDX  = 12'h106;
	localparam logic [11:0] HOLD_IDX       = 12'h108;
	localparam logic [11:0] HIGH_COUNT_IDX = 12'h10a;
	localparam logic [11:0] LOW_PER_IDX    = 12'h10c;
	localparam logic [11:0] HIGH_PER_IDX   = 12'h10e;
	localparam logic [11:0] LOW_CTL_IDX    = 12'h110;
	localparam logic [11:0] HIGH_CTL_IDX   = 12'h112;
	localparam logic [11:0] IRQ_FLAG_IDX   = 12'h114;
	localparam logic [11:0] IRQ_EN_IDX     = 12'h116;
	localparam logic [11:0] LOW_COUNT_ADDR  = 12'(LOW_COUNT_IDX * 4);
	localparam logic [11:0] HOLD_ADDR       = 12'(HOLD_IDX * 4);
	localparam logic [11:0] HIGH_COUNT_ADDR = 12'(HIGH_COUNT_IDX * 4);
	localparam logic [11:0] LOW_PER_ADDR    = 12'(LOW_PER_IDX * 4);
	localparam logic [11:0] HIGH_PER_ADDR   = 12'(HIGH_PER_IDX * 4);
	localparam logic [11:0] LOW_CTL_ADDR    = 12'(LOW_CTL_IDX * 4);
	localparam logic [11:0] HIGH_CTL_ADDR   = 12'(HIGH_CTL_IDX * 4);
	localparam logic [11:0] IRQ_FLAG_ADDR   = 12'(IRQ_FLAG_IDX * 4);
	localparam logic [11:0] IRQ_EN_ADDR     = 12'(IRQ_EN_IDX * 4);
	// control register fields
	localparam int          TIMER_ON_BIT   = 15;
	localparam int          IDLE_STOP_BIT  = 13;
	localparam int          GATE_BIT       = 6;
	localparam int          PS_LSB         = 4;
	localparam int          CHAIN_BIT      = 3;
	localparam int          CLK_SRC_BIT    = 1;
	localparam logic [15:0] LOW_CTL_MASK   = 16'ha07a;
	localparam logic [15:0] HIGH_CTL_MASK  = 16'ha072;
	// flag and enable register fields
	localparam int          LOW_IRQ_BIT    = 0;
	localparam int          HIGH_IRQ_BIT   = 1;
	localparam logic [15:0] CTL_RESET      = 16'h0000;
	localparam logic [15:0] PERIOD_RESET   = 16'hffff;
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	// prescaler terminal counts for divide 1, 8, 64, 256
	localparam logic [7:0]  PS_TERM_DIV1   = 8'h00;
	localparam logic [7:0]  PS_TERM_DIV8   = 8'h07;
	localparam logic [7:0]  PS_TERM_DIV64  = 8'h3f;
	localparam logic [7:0]  PS_TERM_DIV256 = 8'hff;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : paired_timer_pkg

// File: hdl/pin_sync.sv
// two-flop synchroniser for an asynchronous pin
`timescale 1ns/1ps
module pin_sync (
	input  wire logic i_clk,     // system clock
	input  wire logic i_sys_rst, // synchronous reset, high
	input  wire logic i_pin,     // asynchronous pin
	output logic      o_level    // synchronised level
);
	typedef struct packed {
		logic first;
		logic second;
	} sync_s;
	sync_s s;
	sync_s next_s;

	always_comb begin
		next_s.first  = i_pin;
		next_s.second = s.first;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_level = s.second;
endmodule : pin_sync

// File: hdl/timer_prescaler.sv
// clock prescaler dividing input ticks by 1, 8, 64 or 256
`timescale 1ns/1ps
module timer_prescaler
	import paired_timer_pkg::*;
#(
	parameter bit SYNC_OUT = 1'b0
) (
	input  wire logic       i_clk,     // system clock
	input  wire logic       i_sys_rst, // synchronous reset, high
	input  wire logic       i_enable,  // timer on; low halts the prescaler
	input  wire logic       i_clear,   // clear the prescaler count
	input  wire logic       i_tick,    // input tick
	input  wire logic [1:0] i_select,  // prescale select
	output logic            o_tick     // divided tick
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
	} ps_s;
	ps_s        s;
	ps_s        next_s;
	logic [7:0] term;
	logic       pulse;

	always_comb begin
		case (i_select)
			2'h0: term = PS_TERM_DIV1;
			2'h1: term = PS_TERM_DIV8;
			2'h2: term = PS_TERM_DIV64;
			2'h3: term = PS_TERM_DIV256;
			default: term = PS_TERM_DIV1;
		endcase
	end

	always_comb begin
		next_s = s;
		pulse  = 1'b0;
		// halted clock: neither counting nor clearing while disabled
		if (i_enable) begin
			if (i_clear) begin
				next_s.cnt = '0;
			end else if (i_tick) begin
				if (s.cnt >= term) begin
					next_s.cnt = '0;
					pulse      = 1'b1;
				end else begin
					next_s.cnt = s.cnt + 8'h01;
				end
			end
		end
		next_s.tick = pulse;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_tick = SYNC_OUT ? s.tick : pulse;
endmodule : timer_prescaler
